// ---- verilog/rx_ctl_pkg.sv ----
// Purpose: Shared constants and carriers for the telemetry receiver control.
// Assumes: 125 MHz system clock.
// Notes:   Counts are derived from times in their own units.
package rx_ctl_pkg;
	localparam int unsigned CLK_HZ         = 125000000;
	localparam int unsigned BAUD           = 19200;
	localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD;
	localparam int unsigned LEARN_TMO_S    = 10;
	localparam int unsigned ERASE_HOLD_S   = 10;
	localparam int unsigned CARRIER_S      = 5;
	localparam int unsigned DEBOUNCE_MS    = 20;
	localparam int unsigned FLASH_MS       = 200;
	localparam int unsigned STEP_MS        = 250;
	localparam int unsigned LEARN_TMO_CYC  = LEARN_TMO_S * CLK_HZ;
	localparam int unsigned ERASE_CYC      = ERASE_HOLD_S * CLK_HZ;
	localparam int unsigned CARRIER_CYC    = CARRIER_S * CLK_HZ;
	localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned FLASH_CYC      = FLASH_MS * (CLK_HZ / 1000);
	localparam int unsigned STEP_CYC       = STEP_MS * (CLK_HZ / 1000);
	localparam int unsigned PAIR_SLOTS     = 30;
	localparam int unsigned NUM_OUTPUTS    = 4;
	localparam int unsigned FRAME_BYTES    = 7;
	localparam logic [1:0]  ST_LOWBAT_BIT  = 2'h0;
	localparam logic [1:0]  ST_PAIRED_BIT  = 2'h1;
	localparam logic [3:0]  OUT_RESET      = 4'h0;

	// One decoded radio packet as handed over by the modem.
	typedef struct packed {
		logic [23:0] identity;
		logic [15:0] inputs;
		logic        lowBattery;
		logic [7:0]  rssi;
	} packet_s;

	// One pairing entry: transmitter identity and input index to output.
	typedef struct packed {
		logic        used;
		logic [23:0] identity;
		logic [3:0]  inputIdx;
		logic [1:0]  outputIdx;
	} pair_s;
endpackage

// ---- verilog/telemetry_receiver_control.sv ----
// Purpose: Learn, erase, output drive, serial frames and self-test of the
//          telemetry receiver.
// Assumes: Modem supplies decoded packets as one-cycle strobes.
// Notes:   learnIn is the learn pin level (low when grounded); the LED pin
//          is open drain, enable low while driving the LED on.
// Notes on behaviour
// - LED off idle, flickers on packet, lit while learn held low.
// - Each brief learn press selects next output 1..4; LED flashes index.
// - Active input while selected stores pairing; LED flashes twice.
// - Learn abandons after ten seconds without activity.
// - Pairing store holds at most thirty entries.
// - Learn held low ten seconds erases all pairings.
// - LED lit during erase hold; three flashes after release.
// - Digital outputs are active high.
// - Momentary: paired output follows its transmitter input.
// - Latching: paired output toggles on each input falling edge.
// - A frame is sent for each packet received while awake and not already sending.
// - Serial is 19200 baud 8N1 with no handshaking.
// - Identity sent as three bytes, most significant first.
// - Bitmap sent inputs 8..1 then 16..9, one marks active.
// - Status bit0 low battery, bit1 input paired here.
// - Idle listening; on packet process, update outputs, acknowledge.
// - Self-test starts when learn is low at power-on.
// - Self-test walks each output on/off, twice through.
// - Then outputs 1,3 flash five times, then 2,4 five times.
// - Then full-power carrier five seconds with LED flashing.
// - Then RSSI bar graph on outputs until power cycle.
// - Style pin sampled at power-on; low momentary, high latching.
// - Sleep high disables outputs; low permits operation.
`timescale 1ns/1ps
`default_nettype none
module telemetry_receiver_control
	import rx_ctl_pkg::*;
#(
	parameter int unsigned LEARN_TMO = LEARN_TMO_CYC,
	parameter int unsigned ERASE_T   = ERASE_CYC,
	parameter int unsigned CARRIER_T = CARRIER_CYC,
	parameter int unsigned DEBOUNCE  = DEBOUNCE_CYC,
	parameter int unsigned FLASH_T   = FLASH_CYC,
	parameter int unsigned STEP_T    = STEP_CYC,
	parameter int unsigned BIT_T     = BIT_CYCLES
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Pins.
	input  wire logic        learnIn,
	output logic             learnLedOut,
	output logic             learnLedOe_n,
	input  wire logic        output_style_select,
	input  wire logic        sleep,
	output logic [3:0]       digital_outputs,
	output logic             serialOut,
	// Modem side.
	input  wire logic        packetValid,
	input  wire packet_s     packet,
	output logic             ackRequest,
	output logic             carrierOn
);
	typedef enum logic [2:0] {
		S_POR    = 3'h0,
		S_NORMAL = 3'h1,
		S_WALK   = 3'h2,
		S_PAIRS  = 3'h3,
		S_CARRY  = 3'h4,
		S_RSSI   = 3'h5
	} mode_e;

	function automatic logic [3:0] bar(input logic [7:0] r);
		bar = {r >= 8'hC0, r >= 8'h80, r >= 8'h40, r != 8'h00};
	endfunction

	mode_e        mode;
	logic         latching;
	logic [31:0]  modeTimer;
	logic [4:0]   stepCnt;
	logic [3:0]   testOut;
	////////////////////////////////////////////////////////////////////////
	// Debounce and press classification.
	logic         learnLow;
	logic [31:0]  dbCnt;
	logic [31:0]  holdCnt;
	logic         erased;
	logic         briefPress;
	logic         eraseDone;
	always_ff @(posedge clock) begin
		briefPress <= 1'b0;
		eraseDone  <= 1'b0;
		if (!rst_n) begin
			learnLow <= 1'b0;
			dbCnt    <= 32'h0;
			holdCnt  <= 32'h0;
			erased   <= 1'b0;
		end else if ((!learnIn) == learnLow) begin
			dbCnt <= 32'h0;
			if (learnLow && holdCnt < ERASE_T)
				holdCnt <= holdCnt + 32'h1;
			if (learnLow && holdCnt == ERASE_T - 1)
				erased <= 1'b1;
		end else if (dbCnt < DEBOUNCE - 1) begin
			dbCnt <= dbCnt + 32'h1;
		end else begin
			dbCnt    <= 32'h0;
			learnLow <= !learnIn;
			holdCnt  <= 32'h0;
			erased   <= 1'b0;
			if (learnLow && !erased)
				briefPress <= 1'b1;
			if (learnLow && erased)
				eraseDone <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Learn selection and pairing store.
	pair_s        store [PAIR_SLOTS];
	logic [2:0]   selOut;
	logic [31:0]  learnTmr;
	logic         pairedOk;
	logic [15:0]  pairedMask;
	logic [4:0]   freeIdx;
	logic         freeFound;
	logic         wipe;
	logic [3:0]   hitOut [16];
	assign wipe = (holdCnt == ERASE_T - 1) && learnLow;
	always_comb begin
		freeIdx   = 5'h0;
		freeFound = 1'b0;
		pairedMask = 16'h0;
		for (int k = 0; k < 16; k++)
			hitOut[k] = 4'h0;
		for (int i = PAIR_SLOTS - 1; i >= 0; i--) begin
			if (!store[i].used) begin
				freeIdx   = 5'(i);
				freeFound = 1'b1;
			end else if (store[i].identity == packet.identity) begin
				pairedMask[store[i].inputIdx] = 1'b1;
				hitOut[store[i].inputIdx][store[i].outputIdx] = 1'b1;
			end
		end
	end
	always_ff @(posedge clock) begin
		pairedOk <= 1'b0;
		if (!rst_n) begin
			selOut   <= 3'h0;
			learnTmr <= 32'h0;
			for (int i = 0; i < PAIR_SLOTS; i++)
				store[i] <= '0;
		end else if (wipe) begin
			selOut <= 3'h0;
			for (int i = 0; i < PAIR_SLOTS; i++)
				store[i] <= '0;
		end else if (mode == S_NORMAL && briefPress) begin
			selOut   <= (selOut == 3'h4) ? 3'h1 : selOut + 3'h1;
			learnTmr <= 32'h0;
		end else if (selOut != 3'h0) begin
			learnTmr <= learnTmr + 32'h1;
			if (learnTmr >= LEARN_TMO - 1)
				selOut <= 3'h0;
			else if (packetValid && packet.inputs != 16'h0) begin
				selOut <= 3'h0;
				if (freeFound) begin
					store[freeIdx] <= '{1'b1, packet.identity,
						4'(pickLow(packet.inputs)), 2'(selOut - 3'h1)};
					pairedOk <= 1'b1;
				end
			end
		end
	end
	function automatic logic [3:0] pickLow(input logic [15:0] v);
		pickLow = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (v[i])
				pickLow = 4'(i);
	endfunction
	////////////////////////////////////////////////////////////////////////
	// LED flash sequencer.
	logic [3:0]   flashLeft;
	logic [31:0]  flashTmr;
	logic         flashOn;
	logic [31:0]  flickTmr;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flashLeft <= 4'h0;
			flashTmr  <= 32'h0;
			flashOn   <= 1'b0;
		end else if (mode == S_NORMAL && briefPress) begin
			flashLeft <= {(selOut == 3'h4) ? 3'h1 : selOut + 3'h1, 1'b0};
			flashTmr  <= 32'h0;
		end else if (pairedOk) begin
			flashLeft <= 4'h4;
			flashTmr  <= 32'h0;
		end else if (eraseDone) begin
			flashLeft <= 4'h6;
			flashTmr  <= 32'h0;
		end else if (flashLeft != 4'h0) begin
			if (flashTmr >= FLASH_T - 1) begin
				flashTmr  <= 32'h0;
				flashLeft <= flashLeft - 4'h1;
				flashOn   <= !flashLeft[0] ? 1'b1 : 1'b0;
			end else
				flashTmr <= flashTmr + 32'h1;
		end else
			flashOn <= 1'b0;
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			flickTmr <= 32'h0;
		else if (packetValid)
			flickTmr <= FLASH_T;
		else if (flickTmr != 32'h0)
			flickTmr <= flickTmr - 32'h1;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			learnLedOut  <= 1'b1;
			learnLedOe_n <= 1'b1;
		end else begin
			learnLedOut <= 1'b0;
			if (mode == S_CARRY)
				learnLedOe_n <= !modeTimer[24];
			else if (learnLow || flashOn)
				learnLedOe_n <= 1'b0;
			else
				learnLedOe_n <= !(flickTmr[20] | flickTmr[18]);
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Output drive.
	logic [15:0]  prevInputs;
	logic [3:0]   drive;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			drive      <= OUT_RESET;
			prevInputs <= 16'h0;
		end else if (packetValid && mode == S_NORMAL && !sleep) begin
			// Drive ignores packets while sleeping, so it keeps its state.
			prevInputs <= packet.inputs;
			for (int k = 0; k < 16; k++)
				for (int o = 0; o < NUM_OUTPUTS; o++)
					if (hitOut[k][o]) begin
						if (!latching)
							drive[o] <= packet.inputs[k];
						else if (prevInputs[k] && !packet.inputs[k])
							drive[o] <= !drive[o];
					end
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			digital_outputs <= OUT_RESET;
		else if (sleep)
			digital_outputs <= OUT_RESET;
		else if (mode == S_NORMAL)
			digital_outputs <= drive;
		else
			digital_outputs <= testOut;
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			ackRequest <= 1'b0;
		else
			ackRequest <= packetValid && mode == S_NORMAL && !sleep;
	end
	////////////////////////////////////////////////////////////////////////
	// Mode control and self-test.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode      <= S_POR;
			latching  <= 1'b1;
			modeTimer <= 32'h0;
			stepCnt   <= 5'h0;
			testOut   <= 4'h0;
			carrierOn <= 1'b0;
		end else begin
			modeTimer <= modeTimer + 32'h1;
			case (mode)
			S_POR: begin
				latching  <= output_style_select;
				modeTimer <= 32'h0;
				mode      <= learnIn ? S_NORMAL : S_WALK;
			end
			S_NORMAL: modeTimer <= 32'h0;
			S_WALK: if (modeTimer >= STEP_T - 1) begin
				modeTimer <= 32'h0;
				stepCnt   <= stepCnt + 5'h1;
				testOut   <= stepCnt[0] ? 4'h0 : 4'h1 << stepCnt[2:1];
				if (stepCnt == 5'h10) begin
					stepCnt <= 5'h0;
					testOut <= 4'h0;
					mode    <= S_PAIRS;
				end
			end
			S_PAIRS: if (modeTimer >= STEP_T - 1) begin
				modeTimer <= 32'h0;
				stepCnt   <= stepCnt + 5'h1;
				testOut   <= stepCnt[0] ? 4'h0 :
					(stepCnt < 5'hA ? 4'h5 : 4'hA);
				if (stepCnt == 5'h14) begin
					testOut   <= 4'h0;
					carrierOn <= 1'b1;
					mode      <= S_CARRY;
				end
			end
			S_CARRY: if (modeTimer >= CARRIER_T - 1) begin
				carrierOn <= 1'b0;
				mode      <= S_RSSI;
			end
			S_RSSI: begin
				modeTimer <= 32'h0;
				if (packetValid)
					testOut <= bar(packet.rssi);
			end
			default: mode <= S_NORMAL;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Serial frame transmitter, 8N1, one shift per bit time.
	logic [7:0]   frame [FRAME_BYTES];
	logic [2:0]   byteIdx;
	logic [3:0]   bitIdx;
	logic [31:0]  baudTmr;
	logic         busy;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busy      <= 1'b0;
			serialOut <= 1'b1;
			byteIdx   <= 3'h0;
			bitIdx    <= 4'h0;
			baudTmr   <= 32'h0;
			for (int i = 0; i < FRAME_BYTES; i++)
				frame[i] <= 8'h0;
		end else if (packetValid && !busy && !sleep) begin
			frame[0] <= packet.identity[23:16];
			frame[1] <= packet.identity[15:8];
			frame[2] <= packet.identity[7:0];
			frame[3] <= packet.inputs[7:0];
			frame[4] <= packet.inputs[15:8];
			frame[5] <= {6'h0, |(pairedMask & packet.inputs),
				packet.lowBattery};
			frame[6] <= packet.rssi;
			busy      <= 1'b1;
			byteIdx   <= 3'h0;
			bitIdx    <= 4'h0;
			baudTmr   <= 32'h0;
			serialOut <= 1'b0;
		end else if (busy) begin
			if (baudTmr >= BIT_T - 1) begin
				baudTmr <= 32'h0;
				bitIdx  <= bitIdx + 4'h1;
				if (bitIdx < 4'h8)
					serialOut <= frame[byteIdx][bitIdx[2:0]];
				else if (bitIdx == 4'h8)
					serialOut <= 1'b1;
				else begin
					bitIdx <= 4'h0;
					if (byteIdx == 3'(FRAME_BYTES - 1)) begin
						busy <= 1'b0;
					end else begin
						byteIdx   <= byteIdx + 3'h1;
						serialOut <= 1'b0;
					end
				end
			end else
				baudTmr <= baudTmr + 32'h1;
		end
	end
endmodule // telemetry_receiver_control
`default_nettype wire

// ---- verif/rx_ctl_sva.sv ----
// Purpose: Port assertions for the receiver control.
// Assumes: Learn line high at power-on, so no self-test runs.
// Notes:   A high run of ten bit times means the transmitter is idle.
`timescale 1ns/1ps
`default_nettype none
module rx_ctl_sva #(
	parameter int unsigned DEBOUNCE = 4,
	parameter int unsigned BIT_T    = 4
) (
	// Clock and reset.
	input wire logic       clock,
	input wire logic       rst_n,
	// Watched ports.
	input wire logic       learnIn,
	input wire logic       learnLedOut,
	input wire logic       learnLedOe_n,
	input wire logic       sleep,
	input wire logic [3:0] digital_outputs,
	input wire logic       serialOut,
	input wire logic       packetValid,
	input wire logic       ackRequest,
	input wire logic       carrierOn
);
	int unsigned highRun;
	int unsigned lowRun;
	int unsigned holdRun;
	always_ff @(posedge clock) begin
		if (!rst_n || !serialOut) highRun <= 0;
		else if (highRun < 4000) highRun <= highRun + 1;
	end
	always_ff @(posedge clock) begin
		if (!rst_n || serialOut) lowRun <= 0;
		else if (lowRun < 4000) lowRun <= lowRun + 1;
	end
	always_ff @(posedge clock) begin
		if (!rst_n || learnIn) holdRun <= 0;
		else if (holdRun < 4000) holdRun <= holdRun + 1;
	end
	////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		packetValid && !sleep && highRun >= 10 * BIT_T;
	endsequence
	sequence s_start;
		!serialOut ##1 !serialOut;
	endsequence
	a_frame_start: assert property (s_take |=> s_start)
		else $error("no start bit after packet");
	a_sleep_silent: assert property (packetValid && sleep
		&& highRun >= 10 * BIT_T |=> serialOut)
		else $error("frame sent while asleep");
	a_stop_bit: assert property (lowRun <= 9 * BIT_T)
		else $error("line low past a stop bit");
	a_ack_cause: assert property (ackRequest |->
		$past(packetValid) && !$past(sleep))
		else $error("ack without a packet");
	a_ack_answer: assert property (packetValid && !sleep
		&& !carrierOn |=> ackRequest)
		else $error("packet not acknowledged");
	a_sleep_quiet: assert property (sleep [*3] |->
		digital_outputs == 4'h0)
		else $error("output on while asleep");
	a_led_hold: assert property (holdRun > DEBOUNCE + 3
		&& !carrierOn |-> !learnLedOe_n)
		else $error("LED dark while learn held");
	a_led_drive: assert property (!learnLedOe_n |-> !learnLedOut)
		else $error("LED pin driven high");
	a_reset_quiet: assert property ($rose(rst_n) |-> serialOut
		&& learnLedOe_n && digital_outputs == 4'h0 && !carrierOn)
		else $error("outputs not idle after reset");
endmodule // rx_ctl_sva
`default_nettype wire

// ---- verif/uart_host_model.sv ----
// Purpose: Host side receiver of the serial frames.
// Assumes: BIT_T of at least four clocks.
// Notes:   Samples mid-bit and reports the stop bit level.
`timescale 1ns/1ps
`default_nettype none
module uart_host_model #(
	parameter int unsigned BIT_T = 4
) (
	input wire logic  clock,
	input wire logic  rst_n,
	input wire logic  line,
	output logic [7:0] rxByte,
	output logic       rxStrobe,
	output logic       stopBit
);
	initial begin
		rxByte = 8'h00;
		rxStrobe = 1'b0;
		stopBit = 1'b1;
		forever begin
			@(negedge line iff rst_n);
			repeat (BIT_T / 2) @(posedge clock);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_T) @(posedge clock);
				rxByte[i] = line;
			end
			repeat (BIT_T) @(posedge clock);
			stopBit = line;
			rxStrobe = 1'b1;
			@(posedge clock);
			rxStrobe = 1'b0;
		end
	end
endmodule // uart_host_model
`default_nettype wire

// ---- verif/telemetry_receiver_control_test.sv ----
// Purpose: Self-checking bench for the receiver control.
// Assumes: Short parameters stand in for the long timers.
// Notes:   Frames are compared by a monitor against queued notes.
`timescale 1ns/1ps
`default_nettype none
module telemetry_receiver_control_test
	import rx_ctl_pkg::*;
;
	localparam int unsigned DEBOUNCE = 4;
	localparam int unsigned BIT_T    = 4;
	logic        clock, rst_n, learnIn, style, sleep, packetValid;
	packet_s     pkt;
	logic        learnLedOut, learnLedOe_n, serialOut, ackRequest;
	logic        carrierOn, rxStrobe, stopBit;
	logic [3:0]  digital_outputs;
	logic [7:0]  rxByte;
	logic [63:0] expq[$];
	int          n_mismatch = 0;
	int          check_count = 0;
	telemetry_receiver_control #(.LEARN_TMO(200), .ERASE_T(400),
		.CARRIER_T(100), .DEBOUNCE(DEBOUNCE), .FLASH_T(10),
		.STEP_T(10), .BIT_T(BIT_T)) i_telemetry_receiver_control (
		.clock(clock), .rst_n(rst_n), .learnIn(learnIn),
		.learnLedOut(learnLedOut), .learnLedOe_n(learnLedOe_n),
		.output_style_select(style), .sleep(sleep),
		.digital_outputs(digital_outputs), .serialOut(serialOut),
		.packetValid(packetValid), .packet(pkt),
		.ackRequest(ackRequest), .carrierOn(carrierOn));
	uart_host_model #(.BIT_T(BIT_T)) i_uart_host_model (.clock(clock),
		.rst_n(rst_n), .line(serialOut), .rxByte(rxByte),
		.rxStrobe(rxStrobe), .stopBit(stopBit));
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// The low byte of a note masks status bits the bench cannot predict.
	task automatic send(input packet_s p, input logic pd, input logic dc);
		if (!sleep) expq.push_back({p.identity, p.inputs[7:0],
			p.inputs[15:8], 6'h00, pd, p.lowBattery, p.rssi, 6'h00, dc, 1'b0});
		pkt = p;
		packetValid = 1'b1;
		tick(1);
		check(ackRequest, !sleep);
		packetValid = 1'b0;
		tick(330);
	endtask
	task automatic press(input int n, output int cnt);
		logic prev;
		learnIn = 1'b0;
		tick(n);
		check(learnLedOe_n, 1'b0);
		learnIn = 1'b1;
		prev = learnLedOe_n;
		cnt = 0;
		repeat (100) begin
			tick(1);
			if (prev && !learnLedOe_n) cnt++;
			prev = learnLedOe_n;
		end
		check(learnLedOe_n, 1'b1);
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		logic [55:0] got;
		logic [63:0] e;
		forever begin
			for (int k = 0; k < 7; k++) begin
				@(posedge rxStrobe);
				got = {got[47:0], rxByte};
				check(stopBit, 1'b1);
			end
			check(expq.size() > 0, 1'b1);
			e = expq.pop_front();
			check(got | {e[7:0], 8'h00}, e[63:8] | {e[7:0], 8'h00});
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		final_report();
	end
	initial begin
		packet_s     p;
		logic [63:0] r;
		int          cnt;
		{learnIn, style, sleep, packetValid, rst_n} = 5'b10000;
		pkt = '0;
		void'($urandom(32'h72A6));
		repeat (4) @(posedge clock);
		#1 rst_n = 1'b1;
		tick(2);
		repeat (3) begin
			r = {$urandom, $urandom};
			p = r[48:0];
			send(p, 1'b0, 1'b0);
			check(digital_outputs, 4'h0);
		end
		for (int k = 1; k <= 4; k++) begin
			press(10, cnt);
			check(cnt, k);
		end
		p.inputs = 16'h0001 << r[3:0];
		send(p, 1'b0, 1'b1);
		send(p, 1'b1, 1'b0);
		check(digital_outputs, 4'h8);
		p.inputs = 16'hFFFF ^ (16'h0001 << r[3:0]);
		send(p, 1'b0, 1'b0);
		check(digital_outputs, 4'h0);
		press(10, cnt);
		tick(250);
		p.identity = ~p.identity;
		send(p, 1'b0, 1'b0);
		send(p, 1'b0, 1'b0);
		check(digital_outputs, 4'h0);
		p.identity = ~p.identity;
		p.inputs = 16'h0001 << r[3:0];
		sleep = 1'b1;
		send(p, 1'b1, 1'b0);
		check(digital_outputs, 4'h0);
		sleep = 1'b0;
		press(450, cnt);
		check(cnt, 3);
		send(p, 1'b0, 1'b0);
		check(digital_outputs, 4'h0);
		// Style pin is read only after reset, so latching needs a new one.
		rst_n = 1'b0;
		style = 1'b1;
		tick(4);
		rst_n = 1'b1;
		tick(2);
		press(10, cnt);
		check(cnt, 1);
		send(p, 1'b0, 1'b1);
		p.inputs = 16'h0000;
		send(p, 1'b0, 1'b0);
		check(digital_outputs, 4'h1);
		p.inputs = 16'h0001 << r[3:0];
		send(p, 1'b1, 1'b0);
		check(digital_outputs, 4'h1);
		p.inputs = 16'h0000;
		send(p, 1'b0, 1'b0);
		check(digital_outputs, 4'h0);
		check(expq.size(), 0);
		final_report();
	end
endmodule // telemetry_receiver_control_test
bind telemetry_receiver_control rx_ctl_sva #(.DEBOUNCE(DEBOUNCE),
	.BIT_T(BIT_T)) i_rx_ctl_sva (.clock(clock), .rst_n(rst_n),
	.learnIn(learnIn), .learnLedOut(learnLedOut),
	.learnLedOe_n(learnLedOe_n), .sleep(sleep),
	.digital_outputs(digital_outputs), .serialOut(serialOut),
	.packetValid(packetValid), .ackRequest(ackRequest),
	.carrierOn(carrierOn));
`default_nettype wire
